//--- hdl/interp_defines.svh
`ifndef INTERP_DEFINES_SVH
`define INTERP_DEFINES_SVH

// Register offsets, low address byte
`define OFF_CTRL1      8'hb0
`define OFF_ADD0       8'hb4
`define OFF_ADD1       8'hb8
`define OFF_BASE_PACK  8'hbc
`define OFF_ACC0       8'hc0
`define OFF_ACC1       8'hc4
`define OFF_LANE_A_ADDEND      8'hc8
`define OFF_LANE_B_ADDEND      8'hcc
`define OFF_FULL_RESULT_ADDEND      8'hd0
`define OFF_POP0       8'hd4
`define OFF_POP1       8'hd8
`define OFF_POPF       8'hdc
`define OFF_PEEK0      8'he0
`define OFF_PEEK1      8'he4
`define OFF_PEEKF      8'he8
`define OFF_CTRL0      8'hec

// Field positions and widths
`define FORCE_LO       28
`define ADD_W          24
`define HALF_W         16
`define CTRL_W         22
`define HSIZE_WORD     3'h2

// Reset values
`define CTRL_RST       22'h000000
`define WORD_RST       32'h00000000

`endif

//--- hdl/interp_pkg.sv
`default_nettype none
package interp_pkg;

	typedef struct packed {
		logic       two_point_mix_mode;
		logic [1:0] force_msb;
		logic       add_raw;
		logic       swap_result_feedback;
		logic       swap_input_select;
		logic       signed_mode;
		logic [4:0] mask_msb;
		logic [4:0] mask_lsb;
		logic [4:0] shift;
	} lane_ctrl_type;

	typedef struct packed {
		logic       write;
		logic       word;
		logic [7:0] addr;
	} bus_req_type;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_WRITE   = 2'b01,
		ST_RD_WAIT = 2'b11,
		ST_RD_RESP = 2'b10
	} bus_state_type;

endpackage
`default_nettype wire

//--- hdl/dual_lane_interpolator.sv
// The AHB-Lite slave port was decided locally.
`include "interp_defines.svh"
`default_nettype none

// Behaviour
// - Force field ORs into bus-read lane result bits 29:28 only.
// - Raw-add set: lane-1 result uses the unshifted input value.
// - Raw-add affects only the lane result, not the full result.
// - Swap-result set: pop loads accumulator with opposite lane's result.
// - Swap-input set: shift-mask input is opposite lane's accumulator.
// - Input swap sits before raw-add bypass.
// - Signed set: masked value sign-extended to 32 bits before base add.
// - Signed set: pop and peek reads return the sign-extended value.
// - Mask passes bits from upper limit down to lower limit inclusive.
// - Accumulator logically right-shifted before masking.
// - Accumulator-add write adds 24-bit value to the accumulator.
// - Accumulator-add read returns low 24 bits of raw shift-mask value, zero-extended, no base.
// - Packed base write loads both lane bases in one cycle.
// - Packed halves sign- or zero-extended by their lane's signed bit.
// - Pop read returns result and writes both accumulators together.
// - Peek read returns result and changes no state.
// - Each accumulator is a full 32-bit read/write register.
// - Three base registers full 32-bit read/write, reset to zero.
// - Mix mode: lane-1 signed bit picks signed or unsigned interpolation.
module dual_lane_interpolator #(
	parameter int FRAC_W = 8
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic [31:0]      hrdata_out,
	output logic             hresp_out
);

	function automatic logic [31:0] shift_mask(input logic [31:0] v, input interp_pkg::lane_ctrl_type c);
		logic [31:0] hi_keep;
		logic [31:0] m;
		hi_keep = 32'hffffffff >> (5'h1f - c.mask_msb);
		m = (v >> c.shift) & hi_keep & (32'hffffffff << c.mask_lsb);
		if (c.signed_mode && m[c.mask_msb]) begin
			m = m | ~hi_keep;
		end
		return m;
	endfunction

	interp_pkg::bus_state_type state_ff;
	interp_pkg::bus_state_type nxt_state;
	interp_pkg::bus_req_type   req_ff;
	interp_pkg::lane_ctrl_type ctrl0_ff;
	interp_pkg::lane_ctrl_type ctrl1_ff;
	logic [31:0] acc0_ff;
	logic [31:0] acc1_ff;
	logic [31:0] lane_a_addend_ff;
	logic [31:0] lane_b_addend_ff;
	logic [31:0] full_result_addend_ff;
	logic        hreadyout_ff;
	logic [31:0] hrdata_ff;
	logic        hresp_ff;

	// Bus decode
	wire         accept   = hsel_in & htrans_in[1] & hready_in;
	wire         wr_go    = ce_in & (state_ff == interp_pkg::ST_WRITE) & req_ff.word;
	wire         rd_go    = ce_in & (state_ff == interp_pkg::ST_RD_WAIT);
	wire [7:0]   ra       = req_ff.addr;
	wire         is_pop   = (ra == `OFF_POP0) | (ra == `OFF_POP1) | (ra == `OFF_POPF);
	wire         is_peek0 = (ra == `OFF_PEEK0);
	wire         pop_go   = rd_go & is_pop;
	wire         wr_add0  = wr_go & (ra == `OFF_ADD0);
	wire         wr_add1  = wr_go & (ra == `OFF_ADD1);
	wire         wr_pack  = wr_go & (ra == `OFF_BASE_PACK);
	wire         mix      = ctrl0_ff.two_point_mix_mode;

	// Datapath
	// input swap
	wire [31:0]  in0      = ctrl0_ff.swap_input_select ? acc1_ff : acc0_ff;
	wire [31:0]  in1      = ctrl1_ff.swap_input_select ? acc0_ff : acc1_ff;
	wire [31:0]  sm0      = shift_mask(in0, ctrl0_ff);
	wire [31:0]  sm1      = shift_mask(in1, ctrl1_ff);
	wire [31:0]  val0     = ctrl0_ff.add_raw ? in0 : sm0;
	wire [31:0]  val1     = ctrl1_ff.add_raw ? in1 : sm1;

	// mix weight by lane-1 low bits, sign by lane-1 signed bit
	wire [32:0]  b0_ext   = {ctrl1_ff.signed_mode & lane_a_addend_ff[31], lane_a_addend_ff};
	wire [32:0]  b1_ext   = {ctrl1_ff.signed_mode & lane_b_addend_ff[31], lane_b_addend_ff};
	wire [32:0]  diff     = b1_ext - b0_ext;
	wire [FRAC_W:0] frac  = {1'b0, val1[FRAC_W-1:0]};
	wire signed [33+FRAC_W:0] prod = $signed(diff) * $signed(frac);
	wire [31:0]  mix_val  = lane_a_addend_ff + prod[FRAC_W+31:FRAC_W];

	// normal sums; full always from masked values
	wire [31:0]  res0     = mix ? {{(32-FRAC_W){1'b0}}, sm1[FRAC_W-1:0]} : lane_a_addend_ff + val0;
	wire [31:0]  res1     = mix ? mix_val : lane_b_addend_ff + val1;
	wire [31:0]  res_full = mix ? full_result_addend_ff + sm0 : full_result_addend_ff + sm0 + sm1;

	wire [31:0]  force0   = {2'b00, ctrl0_ff.force_msb, 28'h0000000};
	wire [31:0]  force1   = {2'b00, ctrl1_ff.force_msb, 28'h0000000};
	wire [31:0]  bus_res0 = res0 | force0;
	wire [31:0]  bus_res1 = res1 | force1;

	wire [31:0]  pop_acc0 = ctrl0_ff.swap_result_feedback ? res1 : res0;
	wire [31:0]  pop_acc1 = ctrl1_ff.swap_result_feedback ? res0 : res1;

	wire [31:0]  pack0    = {{`HALF_W{ctrl0_ff.signed_mode & hwdata_in[15]}}, hwdata_in[15:0]};
	wire [31:0]  pack1    = {{`HALF_W{ctrl1_ff.signed_mode & hwdata_in[31]}}, hwdata_in[31:16]};
	wire [31:0]  add_val  = {8'h00, hwdata_in[`ADD_W-1:0]};

	// Read mux; unmapped reads zero
	logic [31:0] rd_mux;
	always_comb begin
		case (ra)
			`OFF_CTRL0:     rd_mux = {10'h000, ctrl0_ff};
			`OFF_CTRL1:     rd_mux = {11'h000, ctrl1_ff[20:0]};
			`OFF_ADD0:      rd_mux = {8'h00, sm0[`ADD_W-1:0]};
			`OFF_ADD1:      rd_mux = {8'h00, sm1[`ADD_W-1:0]};
			`OFF_ACC0:      rd_mux = acc0_ff;
			`OFF_ACC1:      rd_mux = acc1_ff;
			`OFF_LANE_A_ADDEND:     rd_mux = lane_a_addend_ff;
			`OFF_LANE_B_ADDEND:     rd_mux = lane_b_addend_ff;
			`OFF_FULL_RESULT_ADDEND:     rd_mux = full_result_addend_ff;
			// lane results with force bits ORed in on pop and peek
			`OFF_POP0:      rd_mux = bus_res0;
			`OFF_POP1:      rd_mux = bus_res1;
			`OFF_POPF:      rd_mux = res_full;
			`OFF_PEEK0:     rd_mux = bus_res0;
			`OFF_PEEK1:     rd_mux = bus_res1;
			`OFF_PEEKF:     rd_mux = res_full;
			default:        rd_mux = `WORD_RST;
		endcase
	end

	always_comb begin
		nxt_state = interp_pkg::ST_IDLE;
		case (state_ff)
			interp_pkg::ST_RD_WAIT: nxt_state = interp_pkg::ST_RD_RESP;
			default: begin
				if (accept) begin
					nxt_state = hwrite_in ? interp_pkg::ST_WRITE : interp_pkg::ST_RD_WAIT;
				end
			end
		endcase
	end

	// Reads take one wait state so read data leaves a flop
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff     <= interp_pkg::ST_IDLE;
			req_ff       <= '0;
			hreadyout_ff <= 1'b1;
			hrdata_ff    <= `WORD_RST;
			hresp_ff     <= 1'b0;
		end else if (ce_in) begin
			state_ff     <= nxt_state;
			hreadyout_ff <= (nxt_state != interp_pkg::ST_RD_WAIT);
			if (accept) begin
				req_ff <= '{write: hwrite_in, word: (hsize_in == `HSIZE_WORD), addr: haddr_in[7:0]};
			end
			if (rd_go) begin
				hrdata_ff <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl0_ff <= `CTRL_RST;
			ctrl1_ff <= `CTRL_RST;
		end else if (wr_go && ra == `OFF_CTRL0) begin
			ctrl0_ff <= hwdata_in[`CTRL_W-1:0];
		end else if (wr_go && ra == `OFF_CTRL1) begin
			ctrl1_ff <= {1'b0, hwdata_in[20:0]};
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			acc0_ff <= `WORD_RST;
			acc1_ff <= `WORD_RST;
		end else if (pop_go) begin
			acc0_ff <= pop_acc0;
			acc1_ff <= pop_acc1;
		end else if (wr_go) begin
			if (ra == `OFF_ACC0) begin
				acc0_ff <= hwdata_in;
			end
			if (wr_add0) begin
				acc0_ff <= acc0_ff + add_val;
			end
			if (ra == `OFF_ACC1) begin
				acc1_ff <= hwdata_in;
			end
			if (wr_add1) begin
				acc1_ff <= acc1_ff + add_val;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lane_a_addend_ff <= `WORD_RST;
			lane_b_addend_ff <= `WORD_RST;
			full_result_addend_ff <= `WORD_RST;
		end else if (wr_pack) begin
			lane_a_addend_ff <= pack0;
			lane_b_addend_ff <= pack1;
		end else if (wr_go) begin
			if (ra == `OFF_LANE_A_ADDEND) begin
				lane_a_addend_ff <= hwdata_in;
			end
			if (ra == `OFF_LANE_B_ADDEND) begin
				lane_b_addend_ff <= hwdata_in;
			end
			if (ra == `OFF_FULL_RESULT_ADDEND) begin
				full_result_addend_ff <= hwdata_in;
			end
		end
	end

	assign hreadyout_out = hreadyout_ff;
	assign hrdata_out    = hrdata_ff;
	assign hresp_out     = hresp_ff;

	// Checks
	sequence rd_wait_s;
		!hreadyout_out && ce_in;
	endsequence

	sequence rd_done_s;
		hreadyout_out;
	endsequence

	property read_latency_p;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && accept && !hwrite_in) |=> rd_wait_s ##1 rd_done_s;
	endproperty

	read_latency_a: assert property (read_latency_p) else $error("read wait state wrong");

	force_bits_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(rd_go && is_peek0) |=> hrdata_out[29:28] == ($past(res0[29:28]) | $past(ctrl0_ff.force_msb)))
		else $error("force bits not on bus read");

	raw_bypass_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(!mix && ctrl1_ff.add_raw) |-> res1 == lane_b_addend_ff + in1)
		else $error("raw add bypass wrong");

	full_masked_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!mix |-> res_full == full_result_addend_ff + sm0 + sm1)
		else $error("full result wrong");

	input_swap_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(ctrl1_ff.swap_input_select && ctrl1_ff.add_raw && !mix) |-> res1 == lane_b_addend_ff + acc0_ff)
		else $error("input swap not ahead of bypass");

	sign_extend_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(ctrl1_ff.signed_mode && sm1[ctrl1_ff.mask_msb]) |-> sm1[31])
		else $error("sign extension missing");

	pop_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
		pop_go |=> (acc0_ff == $past(pop_acc0)) && (acc1_ff == $past(pop_acc1)))
		else $error("pop writeback wrong");

	peek_still_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(rd_go && !is_pop) |=> $stable(acc0_ff) && $stable(acc1_ff) && $stable(lane_a_addend_ff))
		else $error("peek changed state");

	accum_add_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_add0 |=> acc0_ff == $past(acc0_ff) + $past(add_val))
		else $error("accumulator add wrong");

	packed_base_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_pack |=> (lane_a_addend_ff == $past(pack0)) && (lane_b_addend_ff == $past(pack1)))
		else $error("packed base load wrong");

	base_reset_a: assert property (@(posedge clk_in)
		rst_in |=> (lane_a_addend_ff == 32'h00000000) && (full_result_addend_ff == 32'h00000000))
		else $error("base not reset");

	// Lane and bus checks
	hresp_okay_a: assert property (@(posedge clk_in) disable iff (rst_in)
		hresp_out == 1'b0)
		else $error("response not okay");

	force_second_lane_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(rd_go && ra == `OFF_PEEK1) |=> hrdata_out[29:28] == ($past(res1[29:28]) | $past(ctrl1_ff.force_msb)))
		else $error("second_lane force bits not on bus read");

	force_internal_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(pop_go && !ctrl0_ff.swap_result_feedback) |=> acc0_ff == $past(res0))
		else $error("force bits reached accumulator");

	swap_feedback_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(pop_go && ctrl1_ff.swap_result_feedback) |=> acc1_ff == $past(res0))
		else $error("swapped pop feedback wrong");

	swap_input_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ctrl1_ff.swap_input_select |-> sm1 == shift_mask(acc0_ff, ctrl1_ff))
		else $error("input swap wrong");

	sign_fill_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(ctrl0_ff.signed_mode && sm0[ctrl0_ff.mask_msb]) |-> sm0[31])
		else $error("first_lane sign extension missing");

	mask_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(sm1 & ~(32'hffffffff << ctrl1_ff.mask_lsb)) == 32'h00000000)
		else $error("bits below mask lower limit passed");

	mask_high_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!ctrl1_ff.signed_mode |-> (sm1 & ~(32'hffffffff >> (5'h1f - ctrl1_ff.mask_msb))) == 32'h00000000)
		else $error("bits above mask upper limit passed");

	shift_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(ctrl1_ff.mask_lsb == 5'h00 && ctrl1_ff.mask_msb == 5'h1f) |-> sm1 == (in1 >> ctrl1_ff.shift))
		else $error("logical shift wrong");

	lane_b_accumulator_add_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_add1 |=> acc1_ff == $past(acc1_ff) + $past(add_val))
		else $error("accumulator one add wrong");

	add_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(rd_go && ra == `OFF_ADD1) |=> hrdata_out == {8'h00, $past(sm1[23:0])})
		else $error("add port read wrong");

	pack_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_pack |=> $stable(full_result_addend_ff) && $stable(acc0_ff))
		else $error("packed write disturbed other state");

	acc_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(wr_go && ra == `OFF_ACC1) |=> acc1_ff == $past(hwdata_in))
		else $error("accumulator write wrong");

	base_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(wr_go && ra == `OFF_FULL_RESULT_ADDEND) |=> full_result_addend_ff == $past(hwdata_in))
		else $error("base write wrong");

	peek_full_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(rd_go && ra == `OFF_PEEKF) |=> hrdata_out == $past(res_full))
		else $error("full peek wrong");

	pop_second_lane_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(rd_go && ra == `OFF_POP1) |=> hrdata_out == $past(bus_res1))
		else $error("second_lane pop read wrong");

	lane_sum_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(!mix && !ctrl0_ff.add_raw) |-> res0 == lane_a_addend_ff + sm0)
		else $error("first_lane sum wrong");

	mix_other_a: assert property (@(posedge clk_in) disable iff (rst_in)
		mix |-> (res_full == full_result_addend_ff + sm0) && (res0[31:FRAC_W] == '0))
		else $error("mix mode first_lane or full wrong");

	rdata_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!rd_go |=> $stable(hrdata_out))
		else $error("read data changed without read");

endmodule
`default_nettype wire

//--- test/ahb_master_model.sv
`default_nettype none
module ahb_master_model (
	input  wire logic        clk_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hrdata_in,
	output logic             hsel_out,
	output logic [31:0]      haddr_out,
	output logic [1:0]       htrans_out,
	output logic             hwrite_out,
	output logic [2:0]       hsize_out,
	output logic [31:0]      hwdata_out,
	output logic             stb_out,
	output logic [31:0]      data_out,
	output logic             hang_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{hsel_out, haddr_out, htrans_out, hwrite_out, hsize_out} = '0;
		{hwdata_out, stb_out, data_out, hang_out} = '0;
	end

	// Bounded so a stuck slave ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (hready_in !== 1'b1 && n < 20);
		if (hready_in !== 1'b1) hang_out <= 1'b1;
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel_out   <= 1'b1;
		htrans_out <= 2'h2;
		haddr_out  <= {24'h0, a};
		hwrite_out <= w;
		hsize_out  <= 3'h2;
		wait_ready();
		hsel_out   <= 1'b0;
		htrans_out <= 2'h0;
		hwdata_out <= d;
		wait_ready();
		if (!w) begin
			data_out <= hrdata_in;
			stb_out  <= 1'b1;
			@(posedge clk_in);
			stb_out  <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

//--- test/dual_lane_interpolator_tb.sv
`default_nettype none
module dual_lane_interpolator_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                      clk_in, rst_in, hsel, hwrite, hready, hresp, stb, hang;
	logic [31:0]               haddr, hwdata, hrdata, data, d;
	logic [1:0]                htrans;
	logic [2:0]                hsize;
	logic [31:0]               acc[2], base[3], exp_q[$];
	string                     nm_q[$];
	interp_pkg::lane_ctrl_type ctl[2];
	int                        num_errors, comparisons, seed;
	logic [7:0]                regs[10] = '{8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'he0, 8'he4, 8'he8, 8'hb0, 8'hec};

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	dual_lane_interpolator u_dual_lane_interpolator (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata), .hresp_out(hresp));

	ahb_master_model u_ahb_master_model (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata),
		.hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
		.hwdata_out(hwdata), .stb_out(stb), .data_out(data), .hang_out(hang));

	function automatic logic [31:0] lane_in(int l);
		return ctl[l].swap_input_select ? acc[1-l] : acc[l];
	endfunction

	function automatic logic [31:0] sm(int l);
		logic [31:0] v, up;
		up = 32'hffffffff << ctl[l].mask_msb << 1;
		v = (lane_in(l) >> ctl[l].shift) & ~up & (32'hffffffff << ctl[l].mask_lsb);
		if (ctl[l].signed_mode && v[ctl[l].mask_msb]) v = v | up;
		return v;
	endfunction

	function automatic logic [31:0] res(int l);
		logic signed [32:0] b0, b1;
		logic signed [41:0] p;
		logic [31:0]        v1, s1;
		s1 = sm(1);
		v1 = ctl[1].add_raw ? lane_in(1) : s1;
		b0 = {ctl[1].signed_mode & base[0][31], base[0]};
		b1 = {ctl[1].signed_mode & base[1][31], base[1]};
		p = (b1 - b0) * $signed({1'b0, v1[7:0]});
		if (!ctl[0].two_point_mix_mode) return base[l] + (ctl[l].add_raw ? lane_in(l) : sm(l));
		return l == 0 ? {24'h0, s1[7:0]} : base[0] + p[39:8];
	endfunction

	function automatic logic [31:0] bus_lane(int l);
		return res(l) | {ctl[l].force_msb, 28'h0};
	endfunction

	function automatic logic [31:0] full();
		return base[2] + sm(0) + (ctl[0].two_point_mix_mode ? 32'h0 : sm(1));
	endfunction

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] v);
		u_ahb_master_model.xfer(1'b1, a, v);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e);
		exp_q.push_back(e);
		nm_q.push_back($sformatf("read %h", a));
		u_ahb_master_model.xfer(1'b0, a, 32'h0);
	endtask

	// Feedback values are computed before the read changes state
	task automatic pop(logic [7:0] a, logic [31:0] e);
		logic [31:0] r0, r1;
		r0 = res(0);
		r1 = res(1);
		rd(a, e);
		acc[0] = ctl[0].swap_result_feedback ? r1 : r0;
		acc[1] = ctl[1].swap_result_feedback ? r0 : r1;
	endtask

	always @(posedge clk_in) begin
		if (stb === 1'b1) check(nm_q.pop_front(), data, exp_q.pop_front());
		if (stb === 1'b1) check("hresp", {31'h0, hresp}, 32'h0);
		if (hang === 1'b1) begin
			num_errors++;
			stop_test();
		end
	end

	initial begin
		rst_in = 1'b1;
		seed = $urandom(58735);
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		foreach (regs[k]) rd(regs[k], 32'h0);
		rd(8'h40, 32'h0);
		for (int i = 0; i < 40; i++) begin
			for (int l = 0; l < 2; l++) begin
				ctl[l] = 22'($urandom);
				ctl[l].two_point_mix_mode = 1'b0;
				ctl[l].mask_msb = 5'(ctl[l].mask_lsb + $urandom % (32 - ctl[l].mask_lsb));
				acc[l] = $urandom;
				base[l] = $urandom;
			end
			base[2] = $urandom;
			ctl[0].two_point_mix_mode = (i % 5 == 4);
			wr(8'hec, {10'h0, ctl[0]});
			wr(8'hb0, {10'h0, ctl[1]});
			foreach (regs[k]) if (k < 5) wr(regs[k], k < 2 ? acc[k] : base[k-2]);
			rd(8'hc0, acc[0]);
			rd(8'hc4, acc[1]);
			rd(8'hd0, base[2]);
			rd(8'he0, bus_lane(0));
			rd(8'he4, bus_lane(1));
			rd(8'he8, full());
			rd(8'hb4, 32'h00ffffff & sm(0));
			rd(8'hb8, 32'h00ffffff & sm(1));
			rd(8'he0, bus_lane(0));
			case (i % 4)
				0: pop(8'hd4, bus_lane(0));
				1: pop(8'hd8, bus_lane(1));
				2: pop(8'hdc, full());
				default: begin
					d = $urandom & 32'h00ffffff;
					wr(8'hb4, d);
					acc[0] = acc[0] + d;
					d = $urandom & 32'h00ffffff;
					wr(8'hb8, d);
					acc[1] = acc[1] + d;
					d = $urandom;
					wr(8'hbc, d);
					base[0] = ctl[0].signed_mode ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
					base[1] = ctl[1].signed_mode ? {{16{d[31]}}, d[31:16]} : {16'h0, d[31:16]};
				end
			endcase
			rd(8'hc0, acc[0]);
			rd(8'hc4, acc[1]);
			rd(8'hc8, base[0]);
			rd(8'hcc, base[1]);
		end
		repeat (3) @(posedge clk_in);
		stop_test();
	end
endmodule
`default_nettype wire
